// ---- src/wdt_pkg.sv ----
// Shared constants and carriers for the watchdog timer block.
// Assumes one clock domain and a plain address/strobe register port.
package wdt_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W = 15;
  localparam int PRE_W = 8;
  localparam int PSEL_W = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 2;

  // ****************************************************************
  // Register offsets (register index on the plain port)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 4'h4;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int FLAG_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int EN_BIT = 5;
  localparam int CLR_BIT = 4;
  localparam int IDLE_BIT = 3;
  localparam int PS_LSB = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CLR_ONLY_MASK = 8'h10;

  // ****************************************************************
  // Interrupt status fields
  // ****************************************************************
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_PROT_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ****************************************************************
  // Counter constants
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 15'h7FFF;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [PRE_W-1:0] PRE_MASK_SEED = 8'hFE;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  typedef enum logic {
    BOOT_LOAD,
    BOOT_RUN
  } boot_state_e;

  typedef struct packed {
    logic soft_write_protect_fuse;
    logic nonstop_fuse;
    logic hw_enable_fuse;
    logic fused_idle_run;
    logic fused_prescale_2;
    logic fused_prescale_1;
    logic fused_prescale_0;
  } fuse_s;

  typedef struct packed {
    logic watchdog_reset_flag;
    logic watchdog_enable;
    logic counter_clear;
    logic idle_run_select;
    logic [PSEL_W-1:0] prescale_sel;
  } ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage

// ---- src/wdt_prescaler.sv ----
// Selectable-tap prescaler feeding the watchdog time base.
// Assumes step is a one-cycle enable and clr wins over step.
`timescale 1ns/1ps
module wdt_prescaler
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic step,
  input wire logic [wdt_pkg::PSEL_W-1:0] sel,
  output logic tick
);

  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [PRE_W-1:0] tap_mask;

  // Low sel+1 bits all ones means the divide ratio two to the sel+1 is reached
  assign tap_mask = ~(PRE_MASK_SEED << sel);   // see R8
  assign tick = step && ((pre_ff & tap_mask) == tap_mask);

  always_comb
  begin
    nxt_pre = pre_ff;
    if (clr)
    begin
      nxt_pre = PRE_ZERO;
    end
    else if (step)
    begin
      nxt_pre = pre_ff + PRE_ONE;   // see R1
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pre_ff <= PRE_ZERO;
    end
    else
    begin
      pre_ff <= nxt_pre;
    end
  end

endmodule

// ---- src/watchdog_timer.sv ----
// Watchdog timer: control register, prescaled 15-bit counter, warm reset
// request on overflow, fused options and a masked interrupt.
// Assumes rst is the power-on reset; warm_rst is any later system reset.
// Assumes a plain strobe port; read data appear one cycle after the strobe.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - The watchdog is a 15-bit counter stepped by an 8-bit prescaler under one control register.
// R2 - An overflow while enabled requests a system reset.
// R3 - An overflow sets the reset flag in bit 7, which software clears by writing zero.
// R4 - Software writes zero to the reserved bit 6, which reads back as zero.
// R5 - Writing one to the enable bit 5 starts the watchdog and writing zero never clears it.
// R6 - Writing one to the clear bit 4 restarts the count from zero and the bit then self-clears.
// R7 - The idle bit 3 picks halt (0) or keep counting (1) while the processor idles.
// R8 - The prescaler select divides the time base by two to the power of code plus one.
// R9 - With the write-protect fuse set only the clear bit accepts software writes.
// R10 - With the non-stop fuse set the watchdog runs in power-down on the RC oscillator.
// R11 - With the non-stop fuse clear the watchdog stops in power-down.
// R12 - With the hardware-enable fuse set power-up enables the watchdog and loads fused settings.
// R13 - With the hardware-enable fuse clear the watchdog stays off after power-up.
// R14 - The overflow requests a warm reset, not a power-on reset.
// R15 - The warm reset does not clear the reset flag.
// R16 - Overflow happens when the counter wraps from all ones, one step per prescaler pulse.
module watchdog_timer
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_rst,
  input wire wdt_pkg::bus_req_s bus_req,
  output logic [wdt_pkg::DATA_W-1:0] rdata,
  input wire wdt_pkg::fuse_s fuses,
  input wire logic cpu_idle,
  input wire logic cpu_power_down,
  input wire logic rc_tick,
  output logic warm_reset_req,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ctrl_s ctrl_ff;
  ctrl_s nxt_ctrl;
  boot_state_e boot_ff;
  boot_state_e nxt_boot;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic warm_req_ff;
  logic nxt_warm_req;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] nxt_irq_status;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_mask;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] ctrl_view;
  logic ctrl_wr;
  logic prot_hit;
  logic run;
  logic src_step;
  logic pre_tick;
  logic pre_clr;
  logic overflow;

  // ****************************************************************
  // Control register view
  // ****************************************************************
  always_comb
  begin
    ctrl_view = CTRL_RESET;
    ctrl_view[FLAG_BIT] = ctrl_ff.watchdog_reset_flag;
    ctrl_view[RSVD_BIT] = 1'b0;   // see R4
    ctrl_view[EN_BIT] = ctrl_ff.watchdog_enable;
    ctrl_view[CLR_BIT] = ctrl_ff.counter_clear;
    ctrl_view[IDLE_BIT] = ctrl_ff.idle_run_select;
    ctrl_view[PS_LSB +: PSEL_W] = ctrl_ff.prescale_sel;
  end

  assign ctrl_wr = bus_req.wr && (bus_req.addr == ADDR_CTRL);
  // A protected write that tries to change anything but the clear bit is reported
  assign prot_hit = ctrl_wr && fuses.soft_write_protect_fuse &&
                    ((bus_req.wdata & ~CLR_ONLY_MASK) != (ctrl_view & ~CLR_ONLY_MASK));

  // ****************************************************************
  // Control register and power-up fuse load
  // ****************************************************************
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_boot = boot_ff;
    nxt_ctrl.counter_clear = 1'b0;   // see R6
    unique case (boot_ff)
      BOOT_LOAD:
      begin
        // Fuses are sampled the first cycle after power-on reset releases
        if (fuses.hw_enable_fuse)
        begin
          nxt_ctrl.watchdog_enable = 1'b1;   // see R12
          nxt_ctrl.idle_run_select = fuses.fused_idle_run;
          nxt_ctrl.prescale_sel = {fuses.fused_prescale_2, fuses.fused_prescale_1,
                                   fuses.fused_prescale_0};
        end
        nxt_boot = BOOT_RUN;   // see R13
      end
      BOOT_RUN:
      begin
        if (ctrl_wr)
        begin
          nxt_ctrl.counter_clear = bus_req.wdata[CLR_BIT];   // see R6
          if (!fuses.soft_write_protect_fuse)   // see R9
          begin
            if (!bus_req.wdata[FLAG_BIT])
            begin
              nxt_ctrl.watchdog_reset_flag = 1'b0;   // see R3
            end
            // Enable is set-only so runaway code cannot stop the dog
            nxt_ctrl.watchdog_enable = ctrl_ff.watchdog_enable |
                                       bus_req.wdata[EN_BIT];   // see R5
            nxt_ctrl.idle_run_select = bus_req.wdata[IDLE_BIT];
            nxt_ctrl.prescale_sel = bus_req.wdata[PS_LSB +: PSEL_W];
          end
        end
      end
    endcase
    if (warm_rst)
    begin
      nxt_ctrl.counter_clear = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    if (overflow)
    begin
      nxt_ctrl.watchdog_reset_flag = 1'b1;   // see R3
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Bit 6 has no storage, so the reset word skips it
      ctrl_ff <= ctrl_s'({CTRL_RESET[FLAG_BIT], CTRL_RESET[EN_BIT:PS_LSB]});
      boot_ff <= BOOT_LOAD;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;   // see R15
      boot_ff <= nxt_boot;
    end
  end

  // ****************************************************************
  // Time base
  // ****************************************************************
  // Non-stop fuse moves the time base to the RC oscillator pulses
  assign src_step = fuses.nonstop_fuse ? rc_tick : 1'b1;   // see R10
  // Idle and power-down only hold the step; count and prescaler keep their values
  assign run = ctrl_ff.watchdog_enable &&
               !(cpu_idle && !ctrl_ff.idle_run_select) &&   // see R7
               !(cpu_power_down && !fuses.nonstop_fuse);   // see R11
  assign pre_clr = warm_rst || ctrl_ff.counter_clear;

  wdt_prescaler wdt_prescaler_i (
    .clk(clk),
    .rst(rst),
    .clr(pre_clr),
    .step(run && src_step),
    .sel(ctrl_ff.prescale_sel),
    .tick(pre_tick)
  );

  // ****************************************************************
  // Counter and overflow
  // ****************************************************************
  assign overflow = !pre_clr && pre_tick && (cnt_ff == CNT_ALL_ONES);   // see R16

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_warm_req = 1'b0;
    if (pre_clr)
    begin
      nxt_cnt = CNT_ZERO;   // see R6
    end
    else if (pre_tick)
    begin
      nxt_cnt = cnt_ff + CNT_ONE;   // see R1
      // Wrap to zero doubles as the restart after a bite
      nxt_warm_req = overflow;   // see R2
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= CNT_ZERO;
      warm_req_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      warm_req_ff <= nxt_warm_req;
    end
  end

  // Only a warm reset is requested; power-on state is left alone
  assign warm_reset_req = warm_req_ff;   // see R14

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always_comb
  begin
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask = irq_mask_ff;
    if (bus_req.wr && (bus_req.addr == ADDR_IRQ_STATUS))
    begin
      nxt_irq_status = irq_status_ff & ~bus_req.wdata[IRQ_W-1:0];
    end
    if (bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK))
    begin
      nxt_irq_mask = bus_req.wdata[IRQ_W-1:0];
    end
    // Events are applied last so a same-cycle clear cannot lose them
    if (overflow)
    begin
      nxt_irq_status[IRQ_OVF_BIT] = 1'b1;
    end
    if (prot_hit && (boot_ff == BOOT_RUN))
    begin
      nxt_irq_status[IRQ_PROT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_status_ff <= IRQ_RESET;
      irq_mask_ff <= IRQ_RESET;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Level output: stays high while any unmasked sticky bit is set
  assign irq = |(irq_status_ff & irq_mask_ff);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb
  begin
    nxt_rdata = RDATA_IDLE;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        ADDR_CTRL:
        begin
          nxt_rdata = ctrl_view;
        end
        ADDR_IRQ_STATUS:
        begin
          nxt_rdata[IRQ_W-1:0] = irq_status_ff;
        end
        ADDR_IRQ_MASK:
        begin
          nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
        end
        // The count halves are not latched together; software rereads on a carry
        ADDR_COUNT_LO:
        begin
          nxt_rdata = cnt_ff[DATA_W-1:0];
        end
        ADDR_COUNT_HI:
        begin
          nxt_rdata[CNT_W-DATA_W-1:0] = cnt_ff[CNT_W-1:DATA_W];
        end
        default:
        begin
          nxt_rdata = RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_ff <= RDATA_IDLE;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

endmodule

// ---- dv/watchdog_timer_sva.sv ----
// Port checker for the watchdog timer, with its bind.
// Assumes it sees only the top-level ports.
`timescale 1ns/1ps
module watchdog_timer_sva
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire wdt_pkg::bus_req_s bus_req,
  input wire logic [wdt_pkg::DATA_W-1:0] rdata,
  input wire logic warm_reset_req,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Assertions
  // ****
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == RDATA_IDLE)
    else $error("read data not idle");
  chk_rsvd_zero: assert property ((bus_req.rd && bus_req.addr == ADDR_CTRL)
    |=> !rdata[RSVD_BIT]) else $error("reserved bit read as one");
  chk_count_top: assert property ((bus_req.rd && bus_req.addr == ADDR_COUNT_HI)
    |=> !rdata[7]) else $error("count high bit 7 set");
  chk_unmapped_zero: assert property ((bus_req.rd && bus_req.addr > ADDR_COUNT_HI)
    |=> rdata == RDATA_IDLE) else $error("unmapped read not zero");
  chk_pulse_gap: assert property (warm_reset_req |=> !warm_reset_req [*8])
    else $error("reset request too long");
  chk_clear_quiet: assert property ((bus_req.wr && bus_req.addr == ADDR_CTRL
    && bus_req.wdata[CLR_BIT]) |-> ##2 !warm_reset_req [*8])
    else $error("overflow right after clear");
  chk_mask_off: assert property ((bus_req.wr && bus_req.addr == ADDR_IRQ_MASK
    && bus_req.wdata == 8'h00) |=> !irq) else $error("irq with mask zero");
  chk_irq_boot: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  cov_reset_req: cover property (warm_reset_req);
  cov_irq: cover property (irq);
  cov_count_read: cover property (bus_req.rd && bus_req.addr == ADDR_COUNT_LO);
endmodule

bind watchdog_timer watchdog_timer_sva watchdog_timer_sva_i (.clk(clk), .rst(rst),
  .bus_req(bus_req), .rdata(rdata), .warm_reset_req(warm_reset_req), .irq(irq));

// ---- dv/watchdog_timer_test.sv ----
// Self-checking bench for the watchdog timer.
// Assumes wdt_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module watchdog_timer_test;
  import wdt_pkg::*;
  typedef struct packed {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } row_s;
  localparam row_s ROWS [0:9] = '{
    '{1'b0, ADDR_CTRL, 8'h00, 8'h00},
    '{1'b1, ADDR_CTRL, 8'h07, 8'h07},
    '{1'b1, ADDR_CTRL, 8'h08, 8'h08},
    '{1'b1, ADDR_IRQ_MASK, 8'h03, 8'h03},
    '{1'b1, 4'h5, 8'h55, 8'h00},
    '{1'b1, ADDR_IRQ_STATUS, 8'h03, 8'h00},
    '{1'b1, ADDR_CTRL, 8'h30, 8'h30},
    '{1'b0, ADDR_CTRL, 8'h00, 8'h20},
    '{1'b1, ADDR_CTRL, 8'h00, 8'h20},
    '{1'b0, 4'hF, 8'h00, 8'h00}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic warm_rst = 1'b0;
  bus_req_s bus_req = '0;
  fuse_s fuses = '0;
  logic cpu_idle = 1'b0;
  logic cpu_power_down = 1'b0;
  logic rc_tick = 1'b0;
  logic [1:0] rc_cnt = 2'h0;
  logic [DATA_W-1:0] rdata;
  logic warm_reset_req;
  logic irq;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] c0;
  int fails = 0;
  int num_checks = 0;
  int n;

  watchdog_timer watchdog_timer_i (.clk(clk), .rst(rst), .warm_rst(warm_rst),
    .bus_req(bus_req), .rdata(rdata), .fuses(fuses), .cpu_idle(cpu_idle),
    .cpu_power_down(cpu_power_down), .rc_tick(rc_tick),
    .warm_reset_req(warm_reset_req), .irq(irq));

  // ****
  // Clock, RC pulses and tasks
  // ****
  initial
  begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    rc_cnt <= rc_cnt + 2'h1;
    rc_tick <= (rc_cnt == 2'h3);
  end

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Bus tasks start and end on a rising edge and let one idle edge pass,
  // so no signal is driven twice in one time step
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    // Read data stand only in the cycle after the strobe
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Write then read back with no gap, so a one-cycle bit is still seen
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] q);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask

  // Spans are whole tick periods, so the count step is exact
  task automatic measure(input logic [7:0] ctl, input int span, input logic [7:0] exp);
    wr_reg(ADDR_CTRL, ctl);
    rd_reg(ADDR_COUNT_LO, c0);
    repeat (span - 2) @(posedge clk);
    rd_reg(ADDR_COUNT_LO, got);
    check8("count step", exp, got - c0);
  endtask

  // ****
  // Sequence
  // ****
  initial
  begin
    do_reset();
    for (int i = 0; i < 10; i++)
    begin
      if (ROWS[i].w)
        wr_rd(ROWS[i].a, ROWS[i].d, got);
      else
        rd_reg(ROWS[i].a, got);
      check8("row read", ROWS[i].e, got);
    end
    $display("register rows done");
    for (int p = 0; p < 8; p++)
      measure(8'h20 | p[7:0], 4 << (p + 1), 8'h04);
    cpu_idle <= 1'b1;
    measure(8'h20, 64, 8'h00);
    measure(8'h28, 64, 8'h20);
    cpu_idle <= 1'b0;
    cpu_power_down <= 1'b1;
    measure(8'h20, 64, 8'h00);
    fuses.nonstop_fuse <= 1'b1;
    measure(8'h20, 64, 8'h08);
    fuses.nonstop_fuse <= 1'b0;
    cpu_power_down <= 1'b0;
    $display("count rate tests done");
    n = 0;
    wr_reg(ADDR_CTRL, 8'h30);
    while (warm_reset_req !== 1'b1 && n < 70000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 70000)
    begin
      fails++;
      give_verdict();
    end
    // Back onto a rising edge before driving again
    @(posedge clk);
    // A few cycles of slack cover the clear-bit hold cycle
    check8("overflow span", 8'h01, {7'h00, n >= 65532 && n <= 65540});
    warm_rst <= 1'b1;
    @(posedge clk);
    warm_rst <= 1'b0;
    rd_reg(ADDR_CTRL, got);
    check8("flag kept", 8'hA0, got);
    rd_reg(ADDR_IRQ_STATUS, got);
    check8("irq status", 8'h01, got);
    rd_reg(ADDR_COUNT_HI, got);
    check8("count high", 8'h00, got);
    check8("irq on", 8'h01, {7'h00, irq});
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    check8("irq masked", 8'h00, {7'h00, irq});
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    check8("irq unmasked", 8'h01, {7'h00, irq});
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    check8("irq cleared", 8'h00, {7'h00, irq});
    wr_reg(ADDR_CTRL, 8'h20);
    rd_reg(ADDR_CTRL, got);
    check8("flag clear", 8'h20, got);
    $display("overflow test done");
    fuses.soft_write_protect_fuse <= 1'b1;
    wr_reg(ADDR_CTRL, 8'h0F);
    rd_reg(ADDR_CTRL, got);
    check8("protected", 8'h20, got);
    rd_reg(ADDR_IRQ_STATUS, got);
    check8("protect event", 8'h02, got);
    wr_rd(ADDR_CTRL, 8'h30, got);
    check8("clear allowed", 8'h30, got);
    $display("protect test done");
    fuses <= 7'h1D;
    do_reset();
    rd_reg(ADDR_CTRL, got);
    check8("fused load", 8'h2D, got);
    $display("fuse load test done");
    give_verdict();
  end
endmodule
